// File: rtl/imc_counter32.sv
// 16-input module with one 32-bit up/down counter behind a 6+6 byte process image
`timescale 1ns/10ps

// Function
// - Count pulses reach the counter only while the software gate is open.
// - Control bit 0 opens the gate, control bit 1 closes it.
// - Control bit 2 copies the four load bytes into the count.
// - Control bit 3 sets the count to zero.
// - Power-on or backplane reset leaves the count at zero.
// - Count is 32-bit unsigned, up and down, fixed range.
// - Counting up past the maximum wraps to zero.
// - Counting down past zero wraps to the maximum.
// - After a load, counting continues from the loaded value.
// - In frequency mode the load value sets the measuring window length.
// - Input bytes 0 to 3 carry count bytes 0 to 3.
// - Input bytes 4 and 5 carry input levels 0-7 and 8-15.
// - Output byte 5 picks reference rate, codes 0 to 7, others illegal.
// - Load value and reference rate take effect only on control activation.
// - Reads always return the live count and live input levels.
// - Inputs 0 and 1 are both plain inputs and counter channels A, B.
// - Five counter functions, chosen by a one-byte configuration parameter.
// - Six input bytes and six output bytes in host address space.
// - Counter channels are registered correctly at pulse rates up to 100 Hz.
// - Function codes 0 to 4 as listed; other codes are illegal.
// - Quadruple mode uses all A/B edges; A leading counts up.
// - Pulse/direction counts on A rising; B low up, B high down.
module imc_counter32 (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic bus_rst_i,
    input wire logic [15:0] din_i,
    input wire logic out_wr_i,
    input wire logic [2:0] out_addr_i,
    input wire logic [7:0] out_data_i,
    input wire logic in_rd_i,
    input wire logic [2:0] in_addr_i,
    output logic [7:0] in_data_o,
    input wire logic cfg_wr_i,
    input wire logic [7:0] cfg_data_i,
    output logic gate_o
);

    typedef struct packed {
        logic [15:0] sync1;
        logic [15:0] levels;
        logic a_prev;
        logic b_prev;
        logic gate;
        logic [7:0] mode;
        logic [2:0] ref_sel;
        logic [31:0] load_val;
        logic [7:0] ref_byte;
        logic [31:0] count;
        logic [31:0] window;
        logic [31:0] meas;
        logic [31:0] win_cnt;
        logic [7:0] rd_data;
    } imc_state_t;

    localparam imc_state_t ST_RST = '{
        count: imc_pkg::CNT_RST,
        mode: imc_pkg::MODE_RST,
        ref_sel: imc_pkg::REF_RST,
        window: imc_pkg::WINDOW_RST,
        default: '0
    };

    imc_state_t st;
    imc_state_t next_st;
    logic any_rst;
    logic ctrl_wr;
    logic ch_a;
    logic ch_b;
    logic a_rise;
    logic b_rise;
    logic cnt_up;
    logic cnt_dn;
    logic ref_tick;
    logic tick_clr;
    logic [31:0] win_next;
    logic [31:0] edge_inc;

    // Count byte of the live count for image offsets 0..3
    function automatic logic [7:0] imc_byte_of(input logic [31:0] w, input logic [1:0] idx);
        return w[{idx, 3'b000} +: 8];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Shared decodes
    assign any_rst = sys_rst_i || bus_rst_i;
    assign ctrl_wr = out_wr_i && (out_addr_i == imc_pkg::OUT_CTRL);
    assign ch_a = st.levels[0];
    assign ch_b = st.levels[1];
    assign a_rise = ch_a && !st.a_prev;
    assign b_rise = ch_b && !st.b_prev;
    assign edge_inc = 32'(a_rise);
    assign win_next = st.win_cnt + 32'h0000_0001;
    // New rate or window restarts the phase so the first window is full length
    assign tick_clr = bus_rst_i || (ctrl_wr && out_data_i[imc_pkg::CTRL_LOAD]);

    ////////////////////////////////////////////////////////////////////////////
    // Reference tick for frequency and period modes
    imc_ref_tick u_ref_tick (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .clr_i(tick_clr),
        .inc_i(imc_pkg::imc_ref_inc(st.ref_sel)),
        .tick_o(ref_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Count direction per counter function; edges seen on synced levels only
    always_comb begin
        cnt_up = 1'b0;
        cnt_dn = 1'b0;
        case (st.mode)
            imc_pkg::MODE_QUAD: begin
                // Exactly one channel moved: A new vs B old says who leads
                if ((ch_a ^ st.a_prev) ^ (ch_b ^ st.b_prev)) begin
                    cnt_up = ch_a ^ st.b_prev;
                    cnt_dn = !(ch_a ^ st.b_prev);
                end
            end
            imc_pkg::MODE_PULSE: begin
                cnt_up = a_rise && !ch_b;
                cnt_dn = a_rise && ch_b;
            end
            imc_pkg::MODE_UPDN: begin
                // Coincident clocks cancel
                cnt_up = a_rise && !b_rise;
                cnt_dn = b_rise && !a_rise;
            end
            default: begin
                cnt_up = 1'b0;
                cnt_dn = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st = st;
        // Two-flop sync; 40 MHz sampling is far above the 100 Hz pulse rate
        next_st.sync1 = din_i;
        next_st.levels = st.sync1;
        next_st.a_prev = ch_a;
        next_st.b_prev = ch_b;

        // Output image: staged only, nothing takes effect yet
        if (out_wr_i) begin
            if (out_addr_i <= imc_pkg::OUT_LOAD_B3) begin
                next_st.load_val[{out_addr_i[1:0], 3'b000} +: 8] = out_data_i;
            end else if (out_addr_i == imc_pkg::OUT_REF) begin
                next_st.ref_byte = out_data_i;
            end
        end

        // Counting, only through an open gate
        if (st.gate) begin
            case (st.mode)
                imc_pkg::MODE_FREQ: begin
                    // Edges of A within a window of reference ticks
                    next_st.meas = st.meas + edge_inc;
                    if (ref_tick) begin
                        if ((st.window != 32'h0000_0000) && (win_next >= st.window)) begin
                            next_st.count = st.meas + edge_inc;
                            next_st.meas = 32'h0000_0000;
                            next_st.win_cnt = 32'h0000_0000;
                        end else begin
                            next_st.win_cnt = win_next;
                        end
                    end
                end
                imc_pkg::MODE_PERIOD: begin
                    // Reference ticks between rising edges of A
                    if (a_rise) begin
                        next_st.count = st.meas;
                        next_st.meas = 32'(ref_tick);
                    end else if (ref_tick) begin
                        next_st.meas = st.meas + 32'h0000_0001;
                    end
                end
                default: begin
                    // 32-bit arithmetic wraps both ways by itself
                    if (cnt_up) begin
                        next_st.count = st.count + 32'h0000_0001;
                    end else if (cnt_dn) begin
                        next_st.count = st.count - 32'h0000_0001;
                    end
                end
            endcase
        end

        // Control byte actions; the write itself is the activation
        if (ctrl_wr) begin
            if (out_data_i[imc_pkg::CTRL_STOP]) begin
                next_st.gate = 1'b0;
            end else if (out_data_i[imc_pkg::CTRL_START]) begin
                next_st.gate = 1'b1;
            end
            if (out_data_i[imc_pkg::CTRL_LOAD]) begin
                // Illegal rate codes leave the previous rate in force
                if (st.ref_byte <= imc_pkg::REF_MAX_CODE) begin
                    next_st.ref_sel = st.ref_byte[2:0];
                end
                if (st.mode == imc_pkg::MODE_FREQ) begin
                    next_st.window = st.load_val;
                    next_st.meas = 32'h0000_0000;
                    next_st.win_cnt = 32'h0000_0000;
                end else begin
                    next_st.count = st.load_val;
                end
            end
            // Clear beats load when both are asked for
            if (out_data_i[imc_pkg::CTRL_CLEAR]) begin
                next_st.count = imc_pkg::CNT_RST;
                next_st.meas = 32'h0000_0000;
                next_st.win_cnt = 32'h0000_0000;
            end
        end

        // Configuration parameter; illegal codes are ignored
        if (cfg_wr_i && (cfg_data_i <= imc_pkg::MODE_PERIOD)) begin
            next_st.mode = cfg_data_i;
            next_st.meas = 32'h0000_0000;
            next_st.win_cnt = 32'h0000_0000;
        end

        // Input image read, one cycle latency, holds between reads
        if (in_rd_i) begin
            case (in_addr_i)
                imc_pkg::IN_CNT_B0,
                imc_pkg::IN_CNT_B1,
                imc_pkg::IN_CNT_B2,
                imc_pkg::IN_CNT_B3: next_st.rd_data = imc_byte_of(st.count, in_addr_i[1:0]);
                imc_pkg::IN_LEVEL_LO: next_st.rd_data = st.levels[7:0];
                imc_pkg::IN_LEVEL_HI: next_st.rd_data = st.levels[15:8];
                default: next_st.rd_data = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; backplane reset acts like power-on reset
    always_ff @(posedge mclk_i) begin
        if (any_rst) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    assign in_data_o = st.rd_data;
    assign gate_o = st.gate;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_gate_hold;
        @(posedge mclk_i) disable iff (any_rst)
        (!st.gate && !ctrl_wr) |=> (st.count == $past(st.count));
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("count moved with gate closed");

    property p_gate_open;
        @(posedge mclk_i) disable iff (any_rst)
        (ctrl_wr && out_data_i[0] && !out_data_i[1]) |=> gate_o;
    endproperty
    a_gate_open: assert property (p_gate_open) else $error("start did not open gate");

    property p_gate_both;
        @(posedge mclk_i) disable iff (any_rst)
        (ctrl_wr && out_data_i[1]) |=> !gate_o;
    endproperty
    a_gate_both: assert property (p_gate_both) else $error("stop did not close gate");

    property p_load;
        @(posedge mclk_i) disable iff (any_rst)
        (ctrl_wr && out_data_i[2] && !out_data_i[3] && st.mode != imc_pkg::MODE_FREQ)
            |=> (st.count == $past(st.load_val));
    endproperty
    a_load: assert property (p_load) else $error("load value not copied");

    property p_clear;
        @(posedge mclk_i) disable iff (any_rst)
        (ctrl_wr && out_data_i[3]) |=> (st.count == 32'h0000_0000);
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero count");

    property p_bus_reset;
        @(posedge mclk_i) disable iff (sys_rst_i)
        bus_rst_i |=> (st.count == 32'h0000_0000) && !gate_o;
    endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("count not zero after reset");

    property p_wrap_up;
        @(posedge mclk_i) disable iff (any_rst)
        (st.gate && cnt_up && !ctrl_wr && st.count == imc_pkg::CNT_MAX && st.mode <= imc_pkg::MODE_UPDN)
            |=> (st.count == 32'h0000_0000);
    endproperty
    a_wrap_up: assert property (p_wrap_up) else $error("no wrap to zero");

    property p_wrap_dn;
        @(posedge mclk_i) disable iff (any_rst)
        (st.gate && cnt_dn && !ctrl_wr && st.count == 32'h0000_0000 && st.mode <= imc_pkg::MODE_UPDN)
            |=> (st.count == imc_pkg::CNT_MAX);
    endproperty
    a_wrap_dn: assert property (p_wrap_dn) else $error("no wrap to maximum");

    property p_read_count;
        @(posedge mclk_i) disable iff (any_rst)
        (in_rd_i && in_addr_i == 3'h3) |=> (in_data_o == $past(st.count[31:24]));
    endproperty
    a_read_count: assert property (p_read_count) else $error("count byte 3 misplaced");

    property p_read_levels;
        @(posedge mclk_i) disable iff (any_rst)
        (in_rd_i && in_addr_i == 3'h5) |=> (in_data_o == $past(st.levels[15:8]));
    endproperty
    a_read_levels: assert property (p_read_levels) else $error("input levels misplaced");

endmodule

// File: shared/imc_pkg.sv
// Constants and helpers shared by the 32-bit counter input module
package imc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock
    localparam logic [31:0] CLK_HZ = 32'h0262_5A00;

    ////////////////////////////////////////////////////////////////////////////
    // Input image byte offsets
    localparam logic [2:0] IN_CNT_B0 = 3'h0;
    localparam logic [2:0] IN_CNT_B1 = 3'h1;
    localparam logic [2:0] IN_CNT_B2 = 3'h2;
    localparam logic [2:0] IN_CNT_B3 = 3'h3;
    localparam logic [2:0] IN_LEVEL_LO = 3'h4;
    localparam logic [2:0] IN_LEVEL_HI = 3'h5;

    ////////////////////////////////////////////////////////////////////////////
    // Output image byte offsets
    localparam logic [2:0] OUT_LOAD_B3 = 3'h3;
    localparam logic [2:0] OUT_CTRL = 3'h4;
    localparam logic [2:0] OUT_REF = 3'h5;

    ////////////////////////////////////////////////////////////////////////////
    // Control byte bit positions
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_LOAD = 2;
    localparam int CTRL_CLEAR = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Counter function codes
    localparam logic [7:0] MODE_QUAD = 8'h00;
    localparam logic [7:0] MODE_PULSE = 8'h01;
    localparam logic [7:0] MODE_UPDN = 8'h02;
    localparam logic [7:0] MODE_FREQ = 8'h03;
    localparam logic [7:0] MODE_PERIOD = 8'h04;

    ////////////////////////////////////////////////////////////////////////////
    // Reference frequency codes and rates in Hz
    localparam logic [7:0] REF_MAX_CODE = 8'h07;
    localparam logic [31:0] REF_HZ_0 = 32'h00F4_2400;
    localparam logic [31:0] REF_HZ_1 = 32'h007A_1200;
    localparam logic [31:0] REF_HZ_2 = 32'h003D_0900;
    localparam logic [31:0] REF_HZ_3 = 32'h000F_4240;
    localparam logic [31:0] REF_HZ_4 = 32'h0001_86A0;
    localparam logic [31:0] REF_HZ_5 = 32'h0000_2710;
    localparam logic [31:0] REF_HZ_6 = 32'h0000_03E8;
    localparam logic [31:0] REF_HZ_7 = 32'h0000_0064;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset, and the count maximum
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
    localparam logic [31:0] CNT_MAX = 32'hFFFF_FFFF;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [2:0] REF_RST = 3'h0;
    localparam logic [31:0] WINDOW_RST = 32'h0000_0000;

    // Phase increment for a reference rate: f * 2^32 / clock
    function automatic logic [31:0] imc_ref_inc(input logic [2:0] code);
        logic [63:0] f;
        f = 64'h0000_0000_0000_0000;
        case (code)
            3'h0: f = 64'(REF_HZ_0);
            3'h1: f = 64'(REF_HZ_1);
            3'h2: f = 64'(REF_HZ_2);
            3'h3: f = 64'(REF_HZ_3);
            3'h4: f = 64'(REF_HZ_4);
            3'h5: f = 64'(REF_HZ_5);
            3'h6: f = 64'(REF_HZ_6);
            default: f = 64'(REF_HZ_7);
        endcase
        return 32'((f << 32) / 64'(CLK_HZ));
    endfunction

endpackage

// File: rtl/imc_ref_tick.sv
// Fractional reference-rate tick generator
`timescale 1ns/10ps
module imc_ref_tick (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic clr_i,
    input wire logic [31:0] inc_i,
    output logic tick_o
);

    typedef struct packed {
        logic [31:0] acc;
        logic tick;
    } imc_tick_st_t;

    imc_tick_st_t st;
    imc_tick_st_t next_st;
    logic [32:0] sum;

    ////////////////////////////////////////////////////////////////////////////
    // Phase accumulator; carry out is the tick, so 16 MHz works off 40 MHz
    always_comb begin
        next_st = st;
        sum = {1'b0, st.acc} + {1'b0, inc_i};
        next_st.acc = sum[31:0];
        next_st.tick = sum[32];
        // Restart phase so a new window starts aligned
        if (clr_i) begin
            next_st = '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;

    ////////////////////////////////////////////////////////////////////////////
    // Highest rate is below half the clock, so ticks never touch
    property p_tick_spaced;
        @(posedge mclk_i) disable iff (sys_rst_i)
        tick_o |=> !tick_o;
    endproperty
    a_tick_spaced: assert property (p_tick_spaced) else $error("reference ticks back to back");

    property p_tick_clr;
        @(posedge mclk_i) disable iff (sys_rst_i)
        clr_i |=> !tick_o;
    endproperty
    a_tick_clr: assert property (p_tick_clr) else $error("tick after phase restart");

endmodule

// File: bench/imc_host.sv
// Host controller model that writes and reads the process image
`timescale 1ns/10ps
module imc_host (
    input wire logic mclk_i,
    output logic out_wr_o,
    output logic [2:0] out_addr_o,
    output logic [7:0] out_data_o,
    output logic in_rd_o,
    output logic [2:0] in_addr_o,
    input wire logic [7:0] in_data_i,
    output logic cfg_wr_o,
    output logic [7:0] cfg_data_o
);
    // Idle strobes at time zero
    initial begin
        out_wr_o = 1'b0;
        out_addr_o = 3'h0;
        out_data_o = 8'h00;
        in_rd_o = 1'b0;
        in_addr_o = 3'h0;
        cfg_wr_o = 1'b0;
        cfg_data_o = 8'h00;
    end

    // One output image byte; lines flip when released so stale data is never reused
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        out_wr_o = 1'b1;
        out_addr_o = a;
        out_data_o = d;
        @(negedge mclk_i);
        out_wr_o = 1'b0;
        out_addr_o = ~a;
        out_data_o = ~d;
    endtask

    // One input image byte, taken after the answering edge
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(negedge mclk_i);
        in_rd_o = 1'b1;
        in_addr_o = a;
        @(negedge mclk_i);
        in_rd_o = 1'b0;
        in_addr_o = ~a;
        d = in_data_i;
    endtask

    // One-byte counter function parameter
    task automatic cfg(input logic [7:0] code);
        @(negedge mclk_i);
        cfg_wr_o = 1'b1;
        cfg_data_o = code;
        @(negedge mclk_i);
        cfg_wr_o = 1'b0;
        cfg_data_o = ~code;
    endtask
endmodule

// File: bench/imc_counter32_tb.sv
// Self-checking bench for the 32-bit counter input module
`timescale 1ns/10ps
module imc_counter32_tb;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic bus_rst_i = 1'b0;
    logic [15:0] din = 16'h0000;
    logic out_wr, in_rd, cfg_wr, gate;
    logic [2:0] out_addr, in_addr;
    logic [7:0] out_data, in_data, cfg_data, lo, hi;
    logic [31:0] got;
    logic b;
    int failures = 0;
    int samples_checked = 0;
    int unsigned m_cnt = 0;
    int unsigned m_load = 0;
    logic m_gate = 1'b0;
    // Half period of the measured square wave on A, in clocks
    localparam int A_HALF = 100;

    imc_counter32 dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .bus_rst_i(bus_rst_i), .din_i(din),
        .out_wr_i(out_wr), .out_addr_i(out_addr), .out_data_i(out_data), .in_rd_i(in_rd),
        .in_addr_i(in_addr), .in_data_o(in_data), .cfg_wr_i(cfg_wr), .cfg_data_i(cfg_data),
        .gate_o(gate));
    imc_host host (.mclk_i(mclk_i), .out_wr_o(out_wr), .out_addr_o(out_addr), .out_data_o(out_data),
        .in_rd_o(in_rd), .in_addr_o(in_addr), .in_data_i(in_data), .cfg_wr_o(cfg_wr),
        .cfg_data_o(cfg_data));

    // 40 MHz clock
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and comparisons
    task automatic final_report();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            failures++;
        end
    endtask

    // Byte-wise count read; no pulses run meanwhile, so no tearing
    task automatic chk_cnt();
        for (int i = 0; i < 4; i++) begin
            host.rd(3'(i), lo);
            got[8*i +: 8] = lo;
        end
        chk_val("count", m_cnt, got);
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Host actions with model update
    task automatic load(input logic [31:0] v);
        for (int i = 0; i < 4; i++) begin
            host.wr(3'(i), v[8*i +: 8]);
        end
        m_load = v;
    endtask

    // Clear beats load, stop beats start
    task automatic ctrl(input logic [7:0] c);
        host.wr(imc_pkg::OUT_CTRL, c);
        if (c[3]) m_cnt = 0;
        else if (c[2]) m_cnt = m_load;
        if (c[1]) m_gate = 1'b0;
        else if (c[0]) m_gate = 1'b1;
        repeat (2) @(negedge mclk_i);
    endtask

    // Field levels on A and B, held well past sync and edge latency
    task automatic pa(input logic a, input logic bb);
        @(negedge mclk_i);
        din[1:0] = {bb, a};
        repeat (6) @(negedge mclk_i);
    endtask

    task automatic pulse_pd(input logic dir);
        pa(1'b0, dir);
        pa(1'b1, dir);
        pa(1'b0, dir);
        if (m_gate) m_cnt = dir ? m_cnt - 1 : m_cnt + 1;
    endtask

    task automatic quad(input logic fwd);
        if (fwd) begin
            pa(1'b1, 1'b0);
            pa(1'b1, 1'b1);
            pa(1'b0, 1'b1);
            pa(1'b0, 1'b0);
        end else begin
            pa(1'b0, 1'b1);
            pa(1'b1, 1'b1);
            pa(1'b1, 1'b0);
            pa(1'b0, 1'b0);
        end
        if (m_gate) m_cnt = fwd ? m_cnt + 4 : m_cnt - 4;
    endtask

    // Square wave on A; exact period so tick counts per period are whole
    task automatic a_wave(input int n, input int half);
        repeat (n) begin
            din[0] = 1'b1;
            repeat (half) @(negedge mclk_i);
            din[0] = 1'b0;
            repeat (half) @(negedge mclk_i);
        end
    endtask

    // Hang guard
    initial begin
        for (int i = 0; i < 60000; i++) @(posedge mclk_i);
        $display("unexpected timeout expected end seen hang");
        failures++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'hce7d7cfd));
        repeat (2) @(negedge mclk_i);
        sys_rst_i = 1'b0;
        chk_cnt();
        chk_val("gate", 32'h0000_0000, {31'h0, gate});
        done("reset");
        load(32'h1234_5678);
        ctrl(8'h05);
        chk_cnt();
        chk_val("gate", 32'h0000_0001, {31'h0, gate});
        done("load");
        host.cfg(imc_pkg::MODE_PULSE);
        for (int i = 0; i < 8; i++) begin
            b = 1'($urandom);
            pulse_pd(b);
        end
        chk_cnt();
        done("pulse_dir");
        ctrl(8'h03);
        chk_val("gate", 32'h0000_0000, {31'h0, gate});
        repeat (3) pulse_pd(1'b0);
        chk_cnt();
        done("gate");
        load(32'hFFFF_FFFF);
        ctrl(8'h05);
        pulse_pd(1'b0);
        chk_cnt();
        pulse_pd(1'b1);
        chk_cnt();
        done("wrap");
        load($urandom);
        ctrl(8'h01);
        chk_cnt();
        ctrl(8'h0C);
        chk_cnt();
        done("stage_clear");
        // Park B low while in pulse mode, else quadrature starts mid-cycle
        pa(1'b0, 1'b0);
        host.cfg(imc_pkg::MODE_QUAD);
        quad(1'b1);
        quad(1'b1);
        quad(1'b0);
        chk_cnt();
        done("quad");
        host.cfg(imc_pkg::MODE_UPDN);
        host.cfg(8'h09);
        repeat (3) begin
            pa(1'b1, 1'b0);
            pa(1'b0, 1'b0);
            if (m_gate) m_cnt++;
        end
        pa(1'b0, 1'b1);
        pa(1'b0, 1'b0);
        if (m_gate) m_cnt--;
        chk_cnt();
        done("updown");
        // Gate shut so random levels on A and B leave the count alone
        ctrl(8'h02);
        repeat (4) begin
            @(negedge mclk_i);
            din = 16'($urandom);
            repeat (4) @(negedge mclk_i);
            host.rd(imc_pkg::IN_LEVEL_LO, lo);
            host.rd(imc_pkg::IN_LEVEL_HI, hi);
            chk_val("levels", {16'h0, din}, {16'h0, hi, lo});
        end
        host.rd(3'h6, lo);
        chk_val("unmapped", 32'h0000_0000, {24'h0, lo});
        din[1:0] = 2'b00;
        chk_cnt();
        done("levels");
        // Period: reference ticks between A rising edges
        host.wr(imc_pkg::OUT_REF, 8'h02);
        host.cfg(imc_pkg::MODE_PERIOD);
        ctrl(8'h05);
        a_wave(3, A_HALF);
        m_cnt = 32'(64'(imc_pkg::REF_HZ_2) * 64'(2 * A_HALF) / 64'(imc_pkg::CLK_HZ));
        chk_cnt();
        done("period");
        // Frequency: A edges per window of load-value ticks; illegal rate code keeps the old one
        host.cfg(imc_pkg::MODE_FREQ);
        load(32'h0000_0064);
        host.wr(imc_pkg::OUT_REF, 8'h0B);
        ctrl(8'h04);
        a_wave(16, A_HALF);
        m_cnt = 32'(64'(m_load) * 64'(imc_pkg::CLK_HZ) / (64'(imc_pkg::REF_HZ_2) * 64'(2 * A_HALF)));
        chk_cnt();
        done("frequency");
        ctrl(8'h01);
        @(negedge mclk_i);
        bus_rst_i = 1'b1;
        @(negedge mclk_i);
        bus_rst_i = 1'b0;
        m_cnt = 0;
        m_gate = 1'b0;
        chk_cnt();
        chk_val("gate", 32'h0000_0000, {31'h0, gate});
        done("bus_reset");
        final_report();
    end
endmodule
